// ---- sep_consts.vh ----
// Constants for the serial EEPROM command port.
`ifndef SEP_CONSTS_VH
`define SEP_CONSTS_VH

// Core clock period and the self-timed program time, in nanoseconds.
`define SEP_CLK_NS 40
`define SEP_T_PROG_NS 10000000

// Field widths of an instruction frame.
`define SEP_AW_X16 4'h7
`define SEP_AW_X8 4'h8
`define SEP_OPC_W 4'h2
`define SEP_DW_X16 5'h10
`define SEP_DW_X8 5'h08

// Opcodes following the start bit.
`define SEP_OPC_SPECIAL 2'h0
`define SEP_OPC_PROGRAM 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3

// Top two address bits under the special opcode.
`define SEP_SUB_DISABLE 2'h0
`define SEP_SUB_FILL 2'h1
`define SEP_SUB_CLEAR 2'h2
`define SEP_SUB_ENABLE 2'h3

// Kinds of self-timed operation.
`define SEP_KIND_NONE 3'h0
`define SEP_KIND_PROGRAM 3'h1
`define SEP_KIND_ERASE 3'h2
`define SEP_KIND_CLEAR_ALL 3'h3
`define SEP_KIND_FILL_ALL 3'h4

// Value of an erased byte and reset values.
`define SEP_ERASED 8'hff
`define SEP_LATCH_RESET 1'h0

`endif

// ---- sep_sync.v ----
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps
module sep_sync #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sep_sync

// ---- sep_timer.v ----
// Self-timed program/erase timebase, counted on the core clock.
`timescale 1ns/100ps
module sep_timer #(
    parameter CYCLES = 250000,
    parameter WIDTH = 20
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Control
    input wire start,
    output reg busy,
    output reg done
);
    reg [WIDTH-1:0] count_q;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            count_q <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                count_q <= CYCLES[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (busy) begin
                if (count_q == {WIDTH{1'b0}}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // sep_timer

// ---- sep_port.v ----
// Serial EEPROM command port: frame decode, read-out, status and self-timed array updates.
`timescale 1ns/100ps
`include "sep_consts.vh"

// Functional notes
// - Serial input sampled on serial clock rise.
// - Output floats except read data or status.
// - Status drives low while busy, high ready.
// - Dummy one ends status at next fall.
// - Start bit, opcode, address, optional data.
// - Header frames are ten or eleven bits.
// - Read sends dummy zero then word MSB-first.
// - Read bits change on serial clock rise.
// - Program starts on chip select fall.
// - Self-timed cycle needs no serial clock.
// - Program clears location before storing data.
// - Erase leaves every location bit at one.
// - Enable latch cleared at power-up.
// - Enable latch held until disable instruction.
// - Cleared latch ignores program and erase types.
// - Reads work regardless of enable latch.
// - Clear-all sets every array bit to one.
// - Fill-all stores data in every location.
module sep_port #(
    parameter PROG_CYCLES = `SEP_T_PROG_NS / `SEP_CLK_NS,
    parameter [0:0] LARGE_ADDR = 1'b1,
    parameter TIMER_WIDTH = 20
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Serial link pins
    input wire chip_select,
    input wire serial_clock_in,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_en,
    // Organisation strap, high selects 16-bit words
    input wire word_width_select,
    // Status
    output wire busy,
    output wire program_enabled
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_HDR = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_READ = 3'h3;
    localparam [2:0] ST_DONE = 3'h4;

    localparam [3:0] AW16 = `SEP_AW_X16 + {3'h0, LARGE_ADDR};
    localparam [3:0] AW8 = `SEP_AW_X8 + {3'h0, LARGE_ADDR};

    // Synchronised pins.
    wire [3:0] pins_s;
    wire cs_s;
    wire sk_s;
    wire din_s;
    wire org_s;

    sep_sync #(
        .WIDTH(4)
    ) u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({word_width_select, serial_in, serial_clock_in, chip_select}),
        .sync_out(pins_s)
    );

    assign cs_s = pins_s[0];
    assign sk_s = pins_s[1];
    assign din_s = pins_s[2];
    assign org_s = pins_s[3];

    reg sk_prev_q;
    reg cs_prev_q;
    wire sk_rise = sk_s & ~sk_prev_q;
    wire sk_fall = ~sk_s & sk_prev_q;
    wire cs_rise = cs_s & ~cs_prev_q;
    wire cs_fall = ~cs_s & cs_prev_q;

    reg [2:0] state_q;
    reg [3:0] cnt_q;
    reg [10:0] hdr_q;
    reg [4:0] dcnt_q;
    reg [15:0] data_q;
    reg [2:0] kind_q;
    reg [7:0] base_q;
    reg org_op_q;
    reg latch_q;
    reg [7:0] rd_addr_q;
    reg [15:0] rd_sh_q;
    reg [4:0] rcnt_q;
    reg stat_arm_q;
    reg stat_on_q;
    reg end_pend_q;
    reg start_q;

    wire timer_done;
    reg [7:0] mem_q [0:255];

    sep_timer #(
        .CYCLES(PROG_CYCLES),
        .WIDTH(TIMER_WIDTH)
    ) u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(start_q),
        .busy(busy),
        .done(timer_done)
    );

    assign program_enabled = latch_q;

    // Frame geometry follows the strap; the top address bit of the large variant is ignored.
    wire [3:0] aw = org_s ? AW16 : AW8;
    wire [3:0] hdr_len = aw + `SEP_OPC_W;
    wire [4:0] dw = org_s ? `SEP_DW_X16 : `SEP_DW_X8;
    wire [10:0] full = {hdr_q[9:0], din_s};
    wire [10:0] op_sh = full >> aw;
    wire [10:0] sub_sh = full >> (aw - 4'h2);
    wire [1:0] opc = op_sh[1:0];
    wire [1:0] sub = sub_sh[1:0];
    wire [7:0] hdr_addr = org_s ? {full[6:0], 1'b0} : full[7:0];
    wire [7:0] next_addr = rd_addr_q + (org_s ? 8'h02 : 8'h01);
    wire [7:0] fetch_addr = (state_q == ST_HDR) ? hdr_addr : next_addr;
    wire [15:0] fetch_word = org_s ? {mem_q[fetch_addr], mem_q[fetch_addr | 8'h01]}
                                   : {mem_q[fetch_addr], 8'h00};

    always @(posedge core_clk) begin
        if (!reset_n) begin
            sk_prev_q <= 1'b0;
            cs_prev_q <= 1'b0;
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            hdr_q <= 11'h000;
            dcnt_q <= 5'h00;
            data_q <= 16'h0000;
            kind_q <= `SEP_KIND_NONE;
            base_q <= 8'h00;
            org_op_q <= 1'b0;
            latch_q <= `SEP_LATCH_RESET;
            rd_addr_q <= 8'h00;
            rd_sh_q <= 16'h0000;
            rcnt_q <= 5'h00;
            stat_arm_q <= 1'b0;
            stat_on_q <= 1'b0;
            end_pend_q <= 1'b0;
            start_q <= 1'b0;
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
        end else begin
            sk_prev_q <= sk_s;
            cs_prev_q <= cs_s;
            start_q <= 1'b0;
            if (stat_on_q) begin
                serial_out <= ~busy;
            end
            if (cs_fall) begin
                // A frame left short of a complete instruction is simply dropped.
                state_q <= ST_IDLE;
                serial_out_en <= 1'b0;
                stat_on_q <= 1'b0;
                end_pend_q <= 1'b0;
                if (state_q == ST_DONE && kind_q != `SEP_KIND_NONE && latch_q && !busy) begin
                    start_q <= 1'b1;
                    stat_arm_q <= 1'b1;
                end
            end else if (cs_rise) begin
                if (stat_arm_q) begin
                    stat_on_q <= 1'b1;
                    serial_out_en <= 1'b1;
                    serial_out <= ~busy;
                end
            end else if (cs_s) begin
                if (stat_on_q && sk_rise && din_s) begin
                    end_pend_q <= 1'b1;
                end
                if (end_pend_q && sk_fall) begin
                    end_pend_q <= 1'b0;
                    stat_on_q <= 1'b0;
                    stat_arm_q <= 1'b0;
                    serial_out_en <= 1'b0;
                end
                if (sk_rise) begin
                    case (state_q)
                        ST_IDLE: begin
                            // The dummy one that ends status may also open the next frame.
                            if (din_s && !busy) begin
                                state_q <= ST_HDR;
                                cnt_q <= 4'h0;
                                hdr_q <= 11'h000;
                                kind_q <= `SEP_KIND_NONE;
                            end
                        end
                        ST_HDR: begin
                            hdr_q <= full;
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == hdr_len - 4'h1) begin
                                base_q <= hdr_addr;
                                org_op_q <= org_s;
                                dcnt_q <= 5'h00;
                                state_q <= ST_DONE;
                                case (opc)
                                    `SEP_OPC_READ: begin
                                        state_q <= ST_READ;
                                        serial_out_en <= 1'b1;
                                        serial_out <= 1'b0;
                                        rd_addr_q <= hdr_addr;
                                        rd_sh_q <= fetch_word;
                                        rcnt_q <= 5'h00;
                                    end
                                    `SEP_OPC_PROGRAM: begin
                                        kind_q <= `SEP_KIND_PROGRAM;
                                        state_q <= ST_DATA;
                                    end
                                    `SEP_OPC_ERASE: begin
                                        kind_q <= `SEP_KIND_ERASE;
                                    end
                                    default: begin
                                        case (sub)
                                            `SEP_SUB_ENABLE: latch_q <= 1'b1;
                                            `SEP_SUB_DISABLE: latch_q <= 1'b0;
                                            `SEP_SUB_CLEAR: kind_q <= `SEP_KIND_CLEAR_ALL;
                                            default: begin
                                                kind_q <= `SEP_KIND_FILL_ALL;
                                                state_q <= ST_DATA;
                                            end
                                        endcase
                                    end
                                endcase
                            end
                        end
                        ST_DATA: begin
                            data_q <= {data_q[14:0], din_s};
                            dcnt_q <= dcnt_q + 5'h01;
                            if (dcnt_q == dw - 5'h01) begin
                                state_q <= ST_DONE;
                            end
                        end
                        ST_READ: begin
                            serial_out <= rd_sh_q[15];
                            if (rcnt_q == dw - 5'h01) begin
                                // Keep clocking to stream the following words.
                                rcnt_q <= 5'h00;
                                rd_addr_q <= next_addr;
                                rd_sh_q <= fetch_word;
                            end else begin
                                rcnt_q <= rcnt_q + 5'h01;
                                rd_sh_q <= {rd_sh_q[14:0], 1'b0};
                            end
                        end
                        default: begin
                            state_q <= state_q;
                        end
                    endcase
                end
            end
        end
    end

    // Array update at the end of the self-timed cycle; a program overwrites the whole byte,
    // which gives the clear-then-store result without a separate erase.
    genvar gi;
    generate
        for (gi = 0; gi < 256; gi = gi + 1) begin : g_cell
            localparam [7:0] IDX = gi;
            wire all_hit = (kind_q == `SEP_KIND_CLEAR_ALL) || (kind_q == `SEP_KIND_FILL_ALL);
            wire one_hit = (kind_q == `SEP_KIND_PROGRAM || kind_q == `SEP_KIND_ERASE)
                           && (IDX == base_q || (org_op_q && IDX == (base_q | 8'h01)));
            wire clears = (kind_q == `SEP_KIND_ERASE) || (kind_q == `SEP_KIND_CLEAR_ALL);
            wire [7:0] wval = (org_op_q && !IDX[0]) ? data_q[15:8] : data_q[7:0];

            always @(posedge core_clk) begin
                if (!reset_n) begin
                    mem_q[gi] <= `SEP_ERASED;
                end else if (timer_done && (all_hit || one_hit)) begin
                    if (clears) begin
                        mem_q[gi] <= `SEP_ERASED;
                    end else begin
                        mem_q[gi] <= wval;
                    end
                end
            end
        end
    endgenerate
endmodule // sep_port

// ---- sep_port_monitor.sv ----
// Pin-level assertions for the serial EEPROM command port.
`timescale 1ns/100ps
module sep_port_monitor #(
    parameter PROG_CYCLES = 250000
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Serial link pins
    input wire chip_select,
    input wire serial_clock_in,
    input wire serial_out,
    input wire serial_out_en,
    // Status
    input wire busy,
    input wire program_enabled
);
    reg sck_q;
    reg [3:0] since_rise_q;
    reg [3:0] cs_low_q;
    reg [31:0] busy_len_q;
    // The two 4-bit counters saturate, so long idle spans cannot wrap into a false window.
    always @(posedge core_clk) begin
        if (!reset_n) begin
            sck_q <= 1'b0;
            since_rise_q <= 4'hf;
            cs_low_q <= 4'h0;
            busy_len_q <= 32'h0000_0000;
        end else begin
            sck_q <= serial_clock_in;
            since_rise_q <= (serial_clock_in && !sck_q) ? 4'h0 : since_rise_q + {3'h0, since_rise_q != 4'hf};
            cs_low_q <= chip_select ? 4'h0 : cs_low_q + {3'h0, cs_low_q != 4'hf};
            busy_len_q <= busy ? busy_len_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_reset_quiet; disable iff (1'b0) !reset_n |=> !serial_out_en && !busy && !program_enabled; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_float; !chip_select [*5] |-> !serial_out_en; endproperty
    a_float: assert property (p_float) else $error("output driven while deselected");
    property p_dummy_zero; $rose(serial_out_en) && since_rise_q < 4'h8 |-> !serial_out; endproperty
    a_dummy_zero: assert property (p_dummy_zero) else $error("read did not lead with zero");
    property p_read_on_rise; $changed(serial_out) && serial_out_en && $past(serial_out_en) && !$past(busy, 2) && !$past(busy, 3) |-> since_rise_q < 4'h8; endproperty
    a_read_on_rise: assert property (p_read_on_rise) else $error("output bit changed away from a clock rise");
    property p_status_low; busy [*3] ##0 serial_out_en |-> !serial_out; endproperty
    a_status_low: assert property (p_status_low) else $error("status not low while busy");
    property p_busy_start; $rose(busy) |-> cs_low_q >= 4'h3 && cs_low_q <= 4'ha; endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not tied to deselect");
    // The timer holds busy from the load edge to the edge that finds the count at zero.
    property p_busy_len; $fell(busy) |-> busy_len_q == PROG_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("self-timed cycle length wrong");
    property p_busy_latch; $rose(busy) |-> $past(program_enabled); endproperty
    a_busy_latch: assert property (p_busy_latch) else $error("update started while locked");
    property p_latch_frame; $changed(program_enabled) |-> $past(chip_select, 3); endproperty
    a_latch_frame: assert property (p_latch_frame) else $error("latch changed outside a frame");
    c_busy: cover property ($rose(busy));
    c_read: cover property ($rose(serial_out_en) && since_rise_q < 4'h8);
    c_latch: cover property ($rose(program_enabled));
endmodule // sep_port_monitor

bind sep_port sep_port_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_sep_port_monitor (
    .core_clk(core_clk), .reset_n(reset_n), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .busy(busy), .program_enabled(program_enabled));

// ---- sep_host_model.sv ----
// Host model that drives the serial command link from the master side.
`timescale 1ns/100ps
module sep_host_model (
    // Clock
    input wire core_clk,
    // Link pins
    output reg chip_select,
    output reg serial_clock_in,
    output reg serial_in,
    input wire serial_out,
    input wire serial_out_en
);
    reg [31:0] rx_q;
    reg [31:0] en_q;
    initial begin
        chip_select = 1'b0;
        serial_clock_in = 1'b0;
        serial_in = 1'b0;
        rx_q = 32'h0000_0000;
        en_q = 32'h0000_0000;
    end
    // Each capture is taken just before a rise, so it shows the previous rise's result.
    task xfer(input [31:0] bits, input integer n);
        integer i;
        begin
            @(negedge core_clk);
            chip_select = 1'b1;
            for (i = n - 1; i >= 0; i = i - 1) begin
                serial_in = bits[i];
                repeat (4) @(negedge core_clk);
                rx_q = {rx_q[30:0], serial_out};
                en_q = {en_q[30:0], serial_out_en};
                serial_clock_in = 1'b1;
                repeat (4) @(negedge core_clk);
                serial_clock_in = 1'b0;
            end
        end
    endtask
    // The data line toggles once released, since nothing samples it then.
    task drop;
        begin
            @(negedge core_clk);
            chip_select = 1'b0;
            serial_in = ~serial_in;
            repeat (6) @(negedge core_clk);
        end
    endtask
    task raise;
        begin
            @(negedge core_clk);
            chip_select = 1'b1;
            repeat (6) @(negedge core_clk);
        end
    endtask
endmodule // sep_host_model

// ---- testbench.sv ----
// Self-checking testbench for the serial EEPROM command port.
`timescale 1ns/100ps
module testbench;
    reg core_clk;
    reg reset_n;
    reg word_width_select;
    wire chip_select, serial_clock_in, serial_in, serial_out, serial_out_en, busy, program_enabled;
    integer num_errors;
    integer tests_run;
    integer j;
    reg [7:0] mem [0:255];
    sep_port #(.PROG_CYCLES(50), .LARGE_ADDR(1'b1), .TIMER_WIDTH(20)) i_sep_port (
        .core_clk(core_clk), .reset_n(reset_n), .chip_select(chip_select),
        .serial_clock_in(serial_clock_in), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_en(serial_out_en), .word_width_select(word_width_select), .busy(busy),
        .program_enabled(program_enabled));
    sep_host_model i_sep_host_model (
        .core_clk(core_clk), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en));
    always #20 core_clk = ~core_clk;
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task setw(input [7:0] a, input [15:0] d);
        begin
            mem[{a[6:0], 1'h0}] = d[15:8];
            mem[{a[6:0], 1'h1}] = d[7:0];
        end
    endtask
    task rd16(input [7:0] a);
        begin
            i_sep_host_model.xfer({4'h0, 3'h6, a, 17'h0_0000}, 28);
            chk(i_sep_host_model.rx_q[16:0], {1'h0, mem[{a[6:0], 1'h0}], mem[{a[6:0], 1'h1}]});
            chk(i_sep_host_model.en_q[16:0], 17'h1_ffff);
            i_sep_host_model.drop;
        end
    endtask
    task rd8(input [8:0] a);
        begin
            i_sep_host_model.xfer({11'h000, 3'h6, a, 9'h000}, 21);
            chk(i_sep_host_model.rx_q[8:0], {1'h0, mem[a[7:0]]});
            i_sep_host_model.drop;
        end
    endtask
    // An accepted update is polled through status and ended with a dummy one.
    task op(input [31:0] b, input integer n, input ok);
        integer k;
        begin
            i_sep_host_model.xfer(b, n);
            i_sep_host_model.drop;
            if (!ok) begin
                chk(busy, 1'h0);
            end else begin
                i_sep_host_model.raise;
                chk(busy, 1'h1);
                chk({serial_out_en, serial_out}, 2'h2);
                k = 0;
                while (serial_out !== 1'h1 && k < 200) begin
                    @(negedge core_clk);
                    k = k + 1;
                end
                chk({busy, serial_out_en, serial_out}, 3'h3);
                i_sep_host_model.xfer(32'h0000_0001, 1);
                repeat (6) @(negedge core_clk);
                chk(serial_out_en, 1'h0);
                i_sep_host_model.drop;
            end
        end
    endtask
    task done(input [63:0] nm);
        $display("test %0s done, mismatches %0d", nm, num_errors);
    endtask
    task t_locked;
        begin
            chk({serial_out_en, busy, program_enabled}, 3'h0);
            op({5'h00, 3'h5, 8'h05, 16'h1234}, 27, 1'h0);
            op({16'h0440, 16'h1234}, 27, 1'h0);
            op(32'h0000_0480, 11, 1'h0);
            op(32'h0000_0705, 11, 1'h0);
            rd16(8'h05);
            done("locked");
        end
    endtask
    task t_update;
        begin
            op(32'h0000_04c0, 11, 1'h0);
            chk(program_enabled, 1'h1);
            op({5'h00, 3'h5, 8'h05, 16'ha5c3}, 27, 1'h1);
            setw(8'h05, 16'ha5c3);
            rd16(8'h05);
            op({5'h00, 3'h5, 8'h05, 16'h5a3c}, 27, 1'h1);
            setw(8'h05, 16'h5a3c);
            rd16(8'h05);
            rd16(8'h04);
            op(32'h0000_0705, 11, 1'h1);
            setw(8'h05, 16'hffff);
            rd16(8'h05);
            i_sep_host_model.xfer({17'h0_0000, 3'h5, 8'h06, 4'ha}, 15);
            i_sep_host_model.drop;
            chk({busy, program_enabled}, 2'h1);
            rd16(8'h06);
            done("update");
        end
    endtask
    task t_whole;
        begin
            op({16'h0440, 16'hc33c}, 27, 1'h1);
            for (j = 0; j < 128; j = j + 1) setw(j[7:0], 16'hc33c);
            rd16(8'h00);
            rd16(8'hff);
            @(negedge core_clk);
            word_width_select = 1'h0;
            repeat (4) @(negedge core_clk);
            rd8(9'h001);
            rd8(9'h1fe);
            @(negedge core_clk);
            word_width_select = 1'h1;
            repeat (4) @(negedge core_clk);
            op(32'h0000_0480, 11, 1'h1);
            for (j = 0; j < 256; j = j + 1) mem[j] = 8'hff;
            rd16(8'h7f);
            op(32'h0000_0400, 11, 1'h0);
            chk(program_enabled, 1'h0);
            op({5'h00, 3'h5, 8'h03, 16'h0000}, 27, 1'h0);
            rd16(8'h03);
            done("whole");
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // The full run needs under ten thousand cycles, so this limit only cuts a hang.
    initial begin
        #(40 * 40000);
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        core_clk = 1'h0;
        reset_n = 1'h0;
        word_width_select = 1'h1;
        num_errors = 0;
        tests_run = 0;
        for (j = 0; j < 256; j = j + 1) mem[j] = 8'hff;
        repeat (3) @(negedge core_clk);
        reset_n = 1'h1;
        repeat (4) @(negedge core_clk);
        t_locked;
        t_update;
        t_whole;
        tally_and_finish;
    end
endmodule // testbench
